/* src/fpnan_unit.sv */
// Floating point register file, control registers and NaN handling.
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "fpnan_params.svh"
module fpnan_unit
  import fpnan_pkg::*;
#(
  parameter logic NEW_NAN_CAPABLE = 1'b1
)
(
  input  wire logic           CLK,
  input  wire logic           RST_B,
  input  wire logic [4:0]     ADDR,
  input  wire logic [31:0]    WDATA,
  input  wire logic           WR,
  input  wire logic           RD,
  output logic      [31:0]    RDATA,
  input  wire logic           WIDTH_MODE,
  input  wire logic           OP_VALID,
  input  wire fpnan_op_type   OP_CODE,
  input  wire fpnan_fmt_type  OP_FMT,
  input  wire logic [4:0]     SRC_A,
  input  wire logic [4:0]     SRC_B,
  input  wire logic [4:0]     DST,
  input  wire logic [2:0]     CC_INDEX,
  input  wire logic [3:0]     CMP_COND,
  input  wire logic           GPR_IS_ZERO,
  input  wire logic           CVT_SRC_DBL,
  input  wire fpnan_hint_type HINT,
  input  wire logic [63:0]    NORM_RESULT,
  output logic      [63:0]    RESULT,
  output logic                DONE,
  output logic                INVALID,
  output logic                TRAP,
  output logic                UNSUPPORTED
);

  typedef struct packed {
    logic [31:0][63:0] float_register_entry;
    logic [1:0]        rm;
    logic [4:0]        flags;
    logic [4:0]        enables;
    logic [5:0]        cause;
    logic              nan_mode;
    logic [7:0]        fcc;
    logic [31:0]       rdata;
    logic [63:0]       result;
    logic              done;
    logic              inv;
    logic              trap;
    logic              unsup;
  } fpnan_state_type;

  fpnan_state_type st_reg;
  fpnan_state_type st_next;

  // Returns {is_nan, is_signalling}; the top fraction bit means quiet when it equals the mode.
  function automatic logic [1:0] nan_class(input logic [63:0] x, input logic dbl,
                                           input logic mode);
    logic nan;
    logic top;
    nan = dbl ? (&x[62:52] && |x[51:0]) : (&x[30:23] && |x[22:0]);
    top = dbl ? x[51] : x[22];
    return {nan, nan && (top != mode)}; // RL23
  endfunction

  function automatic logic [63:0] default_nan(input logic dbl, input logic mode);
    if (dbl)
    begin
      return mode ? `FPNAN_QNAN_D_NEW : `FPNAN_QNAN_D_OLD; // RL9
    end
    return {32'h00000000, mode ? `FPNAN_QNAN_S_NEW : `FPNAN_QNAN_S_OLD}; // RL8
  endfunction

  // One lane of an arithmetic result with special operands resolved; bit 64 is invalid.
  function automatic logic [64:0] arith_lane(input logic [63:0] a, input logic [63:0] b,
                                             input logic [63:0] norm, input logic dbl,
                                             input logic mode, input fpnan_hint_type hint);
    logic [1:0]  ca;
    logic [1:0]  cb;
    logic [63:0] pick;
    logic        pick_sig;
    ca = nan_class(a, dbl, mode);
    cb = nan_class(b, dbl, mode);
    // Signalling before quiet, then operand A before B, so results repeat exactly.
    if (ca[0] || (!cb[0] && ca[1]))
    begin
      pick = a; // RL24
      pick_sig = ca[0];
    end
    else
    begin
      pick = b; // RL24
      pick_sig = cb[0];
    end
    if (ca[1] || cb[1])
    begin
      if (pick_sig)
      begin
        // Legacy quieting by clearing the top bit could yield infinity, so a fresh NaN is used.
        if (mode)
        begin
          pick[dbl ? 51 : 22] = 1'b1; // RL13 RL2
        end
        else
        begin
          pick = default_nan(dbl, mode); // RL2
        end
      end
      return {ca[0] | cb[0], pick}; // RL1 RL4 RL5 RL12
    end
    if (hint == FPNAN_HINT_INVALID)
    begin
      return {1'b1, default_nan(dbl, mode)}; // RL7
    end
    return {1'b0, norm};
  endfunction

  logic [63:0] op_a;
  logic [63:0] op_b;
  logic [63:0] old_dst;

  // Operand fetch per width mode; the narrow model pairs even and odd entries for doubles.
  always_comb
  begin
    logic [4:0] ae;
    logic [4:0] be;
    logic [4:0] de;
    ae = {SRC_A[4:1], 1'b0};
    be = {SRC_B[4:1], 1'b0};
    de = {DST[4:1], 1'b0};
    op_a = st_reg.float_register_entry[SRC_A];
    op_b = st_reg.float_register_entry[SRC_B];
    old_dst = st_reg.float_register_entry[DST];
    if (!WIDTH_MODE && OP_FMT == FPNAN_FMT_D)
    begin
      op_a = {st_reg.float_register_entry[ae | 5'h01][31:0], st_reg.float_register_entry[ae][31:0]}; // RL18 RL20
      op_b = {st_reg.float_register_entry[be | 5'h01][31:0], st_reg.float_register_entry[be][31:0]};
      old_dst = {st_reg.float_register_entry[de | 5'h01][31:0], st_reg.float_register_entry[de][31:0]};
    end
  end

  always_comb
  begin
    logic [64:0] lane_lo;
    logic [64:0] lane_hi;
    logic [1:0]  cls_lo;
    logic [1:0]  cls_hi;
    logic [63:0] res;
    logic        inv;
    logic        wr_fpr;
    logic        unsup;
    logic        dbl;
    logic        nan_any;
    logic        sig_any;
    logic        take;
    logic [4:0]  de;
    logic [7:0]  fcc_set;
    logic [7:0]  fcc_mask;
    st_next = st_reg;
    lane_lo = '0;
    lane_hi = '0;
    cls_lo = '0;
    cls_hi = '0;
    res = old_dst;
    inv = 1'b0;
    wr_fpr = 1'b0;
    dbl = (OP_FMT == FPNAN_FMT_D);
    nan_any = 1'b0;
    sig_any = 1'b0;
    take = 1'b0;
    de = {DST[4:1], 1'b0};
    fcc_set = '0;
    fcc_mask = '0;
    // Longword and paired formats do not exist in the narrow model.
    unsup = !WIDTH_MODE && (OP_FMT == FPNAN_FMT_L || OP_FMT == FPNAN_FMT_PS); // RL18 RL20
    st_next.done = OP_VALID;
    st_next.rdata = '0;
    if (OP_VALID && !unsup)
    begin
      unique case (OP_CODE)
        FPNAN_OP_ARITH:
        begin
          if (OP_FMT == FPNAN_FMT_PS)
          begin
            lane_lo = arith_lane({32'h0, op_a[31:0]}, {32'h0, op_b[31:0]},
                                 {32'h0, NORM_RESULT[31:0]}, 1'b0, st_reg.nan_mode, HINT);
            lane_hi = arith_lane({32'h0, op_a[63:32]}, {32'h0, op_b[63:32]},
                                 {32'h0, NORM_RESULT[63:32]}, 1'b0, st_reg.nan_mode, HINT);
            res = {lane_hi[31:0], lane_lo[31:0]};
            inv = lane_lo[64] | lane_hi[64]; // RL14
          end
          else
          begin
            lane_lo = arith_lane(op_a, op_b, NORM_RESULT, dbl, st_reg.nan_mode, HINT);
            res = dbl ? lane_lo[63:0] : {old_dst[63:32], lane_lo[31:0]};
            inv = lane_lo[64];
          end
          wr_fpr = 1'b1;
        end
        FPNAN_OP_MOVE_IN:
        begin
          res = (OP_FMT == FPNAN_FMT_S || OP_FMT == FPNAN_FMT_W) ?
                {old_dst[63:32], NORM_RESULT[31:0]} : NORM_RESULT;
          wr_fpr = 1'b1;
        end
        FPNAN_OP_MOVE_OUT:
        begin
          res = op_a;
        end
        FPNAN_OP_COPY, FPNAN_OP_COPY_CT, FPNAN_OP_COPY_CF, FPNAN_OP_COPY_NZ, FPNAN_OP_COPY_Z:
        begin
          unique case (OP_CODE)
            FPNAN_OP_COPY_CT: take = st_reg.fcc[CC_INDEX];
            FPNAN_OP_COPY_CF: take = !st_reg.fcc[CC_INDEX];
            FPNAN_OP_COPY_NZ: take = !GPR_IS_ZERO;
            FPNAN_OP_COPY_Z:  take = GPR_IS_ZERO;
            default:          take = 1'b1;
          endcase
          // Copies are bit-exact and never examine the operand class.
          if (take)
          begin
            res = (OP_FMT == FPNAN_FMT_S || OP_FMT == FPNAN_FMT_W) ?
                  {old_dst[63:32], op_a[31:0]} : op_a; // RL3
          end
          wr_fpr = 1'b1;
        end
        FPNAN_OP_COMPARE:
        begin
          // Low lane, then high lane for paired; unordered answers from CMP_COND[0].
          cls_lo = nan_class(op_a, dbl, st_reg.nan_mode) | nan_class(op_b, dbl, st_reg.nan_mode);
          if (OP_FMT == FPNAN_FMT_PS)
          begin
            cls_lo = nan_class({32'h0, op_a[31:0]}, 1'b0, st_reg.nan_mode) |
                     nan_class({32'h0, op_b[31:0]}, 1'b0, st_reg.nan_mode);
            cls_hi = nan_class({32'h0, op_a[63:32]}, 1'b0, st_reg.nan_mode) |
                     nan_class({32'h0, op_b[63:32]}, 1'b0, st_reg.nan_mode);
            fcc_mask[CC_INDEX] = 1'b1; // RL15
            fcc_mask[CC_INDEX | 3'h1] = 1'b1; // RL16
            fcc_set[CC_INDEX] = cls_lo[1] ? CMP_COND[0] : NORM_RESULT[0];
            fcc_set[CC_INDEX | 3'h1] = cls_hi[1] ? CMP_COND[0] : NORM_RESULT[1]; // RL15
          end
          else
          begin
            fcc_mask[CC_INDEX] = 1'b1;
            fcc_set[CC_INDEX] = cls_lo[1] ? CMP_COND[0] : NORM_RESULT[0];
          end
          nan_any = cls_lo[1] | cls_hi[1];
          sig_any = cls_lo[0] | cls_hi[0];
          inv = sig_any | (CMP_COND[3] & nan_any); // RL6 RL14
          res = {63'h0, fcc_set[CC_INDEX]};
        end
        FPNAN_OP_CVT:
        begin
          cls_lo = nan_class(op_a, CVT_SRC_DBL, st_reg.nan_mode);
          // Integer destinations are signed two's complement; no unsigned form exists.
          if (OP_FMT == FPNAN_FMT_L)
          begin
            res = NORM_RESULT; // RL17
            if (cls_lo[1])
              res = st_reg.nan_mode ? `FPNAN_L_NAN_NEW : `FPNAN_L_POS; // RL11
            else if (HINT == FPNAN_HINT_POS_OVF)
              res = `FPNAN_L_POS; // RL11
            else if (HINT == FPNAN_HINT_NEG_OVF)
              res = st_reg.nan_mode ? `FPNAN_L_NEG_NEW : `FPNAN_L_POS; // RL11
          end
          else
          begin
            res = {old_dst[63:32], NORM_RESULT[31:0]}; // RL17
            if (cls_lo[1])
              res[31:0] = st_reg.nan_mode ? `FPNAN_W_NAN_NEW : `FPNAN_W_POS; // RL10
            else if (HINT == FPNAN_HINT_POS_OVF)
              res[31:0] = `FPNAN_W_POS; // RL10
            else if (HINT == FPNAN_HINT_NEG_OVF)
              res[31:0] = st_reg.nan_mode ? `FPNAN_W_NEG_NEW : `FPNAN_W_POS; // RL10
          end
          inv = cls_lo[1] | (HINT != FPNAN_HINT_NONE);
          wr_fpr = 1'b1;
        end
        default:
        begin
          unsup = 1'b1;
        end
      endcase
    end
    st_next.unsup = OP_VALID && unsup;
    st_next.inv = OP_VALID && !unsup && inv;
    // An enabled invalid trap suppresses the register file and fcc updates; RESULT still loads.
    st_next.trap = OP_VALID && !unsup && inv && st_reg.enables[`FPNAN_INV_BIT];
    st_next.result = (OP_VALID && !unsup) ? res : st_reg.result;
    if (OP_VALID && !unsup && !st_next.trap)
    begin
      st_next.fcc = (st_reg.fcc & ~fcc_mask) | fcc_set;
      if (wr_fpr)
      begin
        if (!WIDTH_MODE && OP_FMT == FPNAN_FMT_D)
        begin
          st_next.float_register_entry[de][31:0] = res[31:0]; // RL18 RL20
          st_next.float_register_entry[de | 5'h01][31:0] = res[63:32];
        end
        else
        begin
          st_next.float_register_entry[DST] = res; // RL19 RL21
        end
      end
    end
    // Software writes go first so a same-cycle raised flag is ORed on top and never lost.
    if (WR)
    begin
      unique case (ADDR)
        `FPNAN_ADDR_CSR:
        begin
          st_next.rm = WDATA[`FPNAN_CSR_RM_LSB +: 2]; // RL22
          st_next.flags = WDATA[`FPNAN_CSR_FLAG_LSB +: 5];
          st_next.enables = WDATA[`FPNAN_CSR_EN_LSB +: 5];
          st_next.cause = WDATA[`FPNAN_CSR_CAUSE_LSB +: 6];
          st_next.nan_mode = NEW_NAN_CAPABLE & WDATA[`FPNAN_CSR_NAN_BIT];
          st_next.fcc = {WDATA[`FPNAN_CSR_CCHI_LSB +: 7], WDATA[`FPNAN_CSR_CC0_BIT]};
        end
        `FPNAN_ADDR_CCALIAS: st_next.fcc = WDATA[7:0]; // RL22
        `FPNAN_ADDR_EXALIAS:
        begin
          st_next.flags = WDATA[`FPNAN_CSR_FLAG_LSB +: 5];
          st_next.cause = WDATA[`FPNAN_CSR_CAUSE_LSB +: 6];
        end
        `FPNAN_ADDR_ENALIAS:
        begin
          st_next.rm = WDATA[`FPNAN_CSR_RM_LSB +: 2];
          st_next.enables = WDATA[`FPNAN_CSR_EN_LSB +: 5];
        end
        default:
        begin
        end
      endcase
    end
    if (OP_VALID && !unsup)
    begin
      st_next.cause[`FPNAN_INV_BIT] = inv; // RL1 RL14
      st_next.flags[`FPNAN_INV_BIT] = st_next.flags[`FPNAN_INV_BIT] |
                                      (inv && !st_next.trap);
    end
    if (RD)
    begin
      unique case (ADDR)
        `FPNAN_ADDR_IDENT:
          st_next.rdata = `FPNAN_ID_CAPS | ({31'h0, NEW_NAN_CAPABLE} << `FPNAN_ID_NEWNAN_BIT) |
                          {16'h0, `FPNAN_ID_PROC, `FPNAN_ID_REV};
        `FPNAN_ADDR_CSR:
          st_next.rdata = {st_reg.fcc[7:1], 1'b0, st_reg.fcc[0], 4'h0, st_reg.nan_mode,
                           st_reg.cause, st_reg.enables, st_reg.flags, st_reg.rm}; // RL22
        `FPNAN_ADDR_CCALIAS: st_next.rdata = {24'h0, st_reg.fcc};
        `FPNAN_ADDR_EXALIAS: st_next.rdata = {14'h0, st_reg.cause, 5'h0, st_reg.flags, 2'h0};
        `FPNAN_ADDR_ENALIAS: st_next.rdata = {20'h0, st_reg.enables, 5'h0, st_reg.rm};
        default:             st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign RDATA = st_reg.rdata;
  assign RESULT = st_reg.result;
  assign DONE = st_reg.done;
  assign INVALID = st_reg.inv;
  assign TRAP = st_reg.trap;
  assign UNSUPPORTED = st_reg.unsup;

endmodule

/* common/fpnan_params.svh */
// Constants for the floating point special-operand unit.
// Operation
// [RL1] Signalling NaN operand raises invalid operation.
// [RL2] Never deliver a signalling NaN result.
// [RL3] Register copies pass NaNs, raise nothing.
// [RL4] Quiet NaN operands raise no exception.
// [RL5] Quiet NaN operand gives quiet NaN result.
// [RL6] Comparisons treat quiet NaN like signalling; the code does so only when CMP_COND[3] is set.
// [RL7] Untrapped invalid makes fresh default NaN.
// [RL8] Single default NaN chosen by mode.
// [RL9] Double default NaN chosen by mode.
// [RL10] Word conversion overflow and NaN values.
// [RL11] Longword conversion overflow and NaN values.
// [RL12] New mode: quiet NaN mantissa passed unchanged.
// [RL13] New mode: signalling NaN only gets quieted.
// [RL14] Paired halves' exceptions ORed together.
// [RL15] Paired compare writes index and index+1.
// [RL16] Software gives even index for paired compare.
// [RL17] Fixed point is signed two's complement.
// [RL18] Narrow model: 32x32, doubles in pairs.
// [RL19] Wide model: 32x64, any format.
// [RL20] Width mode bit clear selects narrow model.
// [RL21] Both register models supported.
// [RL22] Five control registers, three are aliases.
// [RL23] Top fraction bit meaning flips by mode.
// [RL24] Fixed priority picks the propagated NaN.
`ifndef FPNAN_PARAMS_SVH
`define FPNAN_PARAMS_SVH
`define FPNAN_ADDR_IDENT   5'h00
`define FPNAN_ADDR_CCALIAS 5'h19
`define FPNAN_ADDR_EXALIAS 5'h1a
`define FPNAN_ADDR_ENALIAS 5'h1c
`define FPNAN_ADDR_CSR     5'h1f
`define FPNAN_CSR_RM_LSB     0
`define FPNAN_CSR_FLAG_LSB   2
`define FPNAN_CSR_EN_LSB     7
`define FPNAN_CSR_CAUSE_LSB  12
`define FPNAN_CSR_NAN_BIT    18
`define FPNAN_CSR_CC0_BIT    23
`define FPNAN_CSR_CCHI_LSB   25
`define FPNAN_INV_BIT        4
`define FPNAN_ID_NEWNAN_BIT  23
// Identity values below are arbitrary.
`define FPNAN_ID_CAPS        32'h007b0000
`define FPNAN_ID_PROC        8'h5a
`define FPNAN_ID_REV         8'h01
`define FPNAN_QNAN_S_OLD     32'h7fbfffff
`define FPNAN_QNAN_S_NEW     32'h7fc00000
`define FPNAN_QNAN_D_OLD     64'h7ff7ffffffffffff
`define FPNAN_QNAN_D_NEW     64'h7ff8000000000000
`define FPNAN_W_POS          32'h7fffffff
`define FPNAN_W_NAN_NEW      32'h00000000
`define FPNAN_W_NEG_NEW      32'h80000000
`define FPNAN_L_POS          64'h7fffffffffffffff
`define FPNAN_L_NAN_NEW      64'h0000000000000000
`define FPNAN_L_NEG_NEW      64'h8000000000000000
`endif

/* common/fpnan_pkg.sv */
// Types shared by the floating point special-operand unit.
package fpnan_pkg;
  typedef enum logic [3:0] {
    FPNAN_OP_ARITH    = 4'h0,
    FPNAN_OP_MOVE_IN  = 4'h1,
    FPNAN_OP_MOVE_OUT = 4'h2,
    FPNAN_OP_COPY     = 4'h3,
    FPNAN_OP_COPY_CT  = 4'h4,
    FPNAN_OP_COPY_CF  = 4'h5,
    FPNAN_OP_COPY_NZ  = 4'h6,
    FPNAN_OP_COPY_Z   = 4'h7,
    FPNAN_OP_COMPARE  = 4'h8,
    FPNAN_OP_CVT      = 4'h9
  } fpnan_op_type;
  typedef enum logic [2:0] {
    FPNAN_FMT_S  = 3'h0,
    FPNAN_FMT_D  = 3'h1,
    FPNAN_FMT_W  = 3'h2,
    FPNAN_FMT_L  = 3'h3,
    FPNAN_FMT_PS = 3'h4
  } fpnan_fmt_type;
  typedef enum logic [1:0] {
    FPNAN_HINT_NONE    = 2'h0,
    FPNAN_HINT_INVALID = 2'h1,
    FPNAN_HINT_POS_OVF = 2'h2,
    FPNAN_HINT_NEG_OVF = 2'h3
  } fpnan_hint_type;
endpackage

/* testbench/fpnan_unit_sva.sv */
// Port-level checks for the special-operand unit.
`timescale 1ns/1ps
module fpnan_unit_sva
  import fpnan_pkg::*;
#(
  parameter logic NEW_NAN_CAPABLE = 1'b1
)
(
  input wire logic           CLK,
  input wire logic           RST_B,
  input wire logic [4:0]     ADDR,
  input wire logic [31:0]    WDATA,
  input wire logic           WR,
  input wire logic           RD,
  input wire logic [31:0]    RDATA,
  input wire logic           WIDTH_MODE,
  input wire logic           OP_VALID,
  input wire fpnan_op_type   OP_CODE,
  input wire fpnan_fmt_type  OP_FMT,
  input wire fpnan_hint_type HINT,
  input wire logic [63:0]    RESULT,
  input wire logic           DONE,
  input wire logic           INVALID,
  input wire logic           TRAP,
  input wire logic           UNSUPPORTED
);
  logic mode_reg;
  // The NaN mode is mirrored from bus writes, so conversions are judged without internals.
  always_ff @(posedge CLK or negedge RST_B)
    if (!RST_B)
      mode_reg <= 1'b0;
    else if (WR && ADDR == 5'h1f && NEW_NAN_CAPABLE)
      mode_reg <= WDATA[18];
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  a_done_follow:
    assert property (OP_VALID |=> DONE) else $error("no done after issue");
  a_done_cause:
    assert property (DONE |-> $past(OP_VALID)) else $error("done without issue");
  a_rdata_idle:
    assert property (!$past(RD) |-> RDATA == 32'h0) else $error("read data outside slot");
  a_copy_quiet:
    assert property (OP_VALID && OP_CODE inside {FPNAN_OP_COPY, FPNAN_OP_COPY_CT,
      FPNAN_OP_COPY_CF, FPNAN_OP_COPY_NZ, FPNAN_OP_COPY_Z} |=> !INVALID)
      else $error("copy raised invalid");
  a_narrow_refused:
    assert property (OP_VALID && !WIDTH_MODE && OP_FMT inside {FPNAN_FMT_L, FPNAN_FMT_PS}
      |=> UNSUPPORTED) else $error("narrow model took a wide format");
  a_wide_accepted:
    assert property (OP_VALID && WIDTH_MODE && OP_CODE == FPNAN_OP_COPY |=> !UNSUPPORTED)
      else $error("wide model refused a copy");
  a_refused_quiet:
    assert property (UNSUPPORTED |-> !INVALID && !TRAP) else $error("refused op flagged");
  a_trap_invalid:
    assert property (TRAP |-> INVALID) else $error("trap without invalid");
  a_word_overflow:
    assert property (OP_VALID && OP_CODE == FPNAN_OP_CVT && OP_FMT == FPNAN_FMT_W &&
      HINT == FPNAN_HINT_POS_OVF |=> RESULT[31:0] == 32'h7fffffff)
      else $error("word overflow value wrong");
  a_long_negative:
    assert property (OP_VALID && OP_CODE == FPNAN_OP_CVT && OP_FMT == FPNAN_FMT_L &&
      WIDTH_MODE && HINT == FPNAN_HINT_NEG_OVF |=> RESULT == ($past(mode_reg) ?
      64'h8000000000000000 : 64'h7fffffffffffffff)) else $error("long underflow value wrong");
endmodule
bind fpnan_unit fpnan_unit_sva #(.NEW_NAN_CAPABLE(NEW_NAN_CAPABLE)) u_sva (
  .CLK(CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .WIDTH_MODE(WIDTH_MODE), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE), .OP_FMT(OP_FMT),
  .HINT(HINT), .RESULT(RESULT), .DONE(DONE), .INVALID(INVALID), .TRAP(TRAP),
  .UNSUPPORTED(UNSUPPORTED));

/* testbench/fpnan_cpu_model.sv */
// Instruction issue side of the special-operand unit.
`timescale 1ns/1ps
module fpnan_cpu_model
  import fpnan_pkg::*;
(
  input  wire logic     clk,
  output logic          op_valid,
  output fpnan_op_type  op_code,
  output fpnan_fmt_type op_fmt,
  output logic [4:0]    src_a,
  output logic [4:0]    src_b,
  output logic [4:0]    dst,
  output logic [2:0]    cc_index,
  output logic [3:0]    cmp_cond,
  output logic          gpr_is_zero,
  output logic          cvt_src_dbl,
  output fpnan_hint_type hint,
  output logic [63:0]   norm_result
);
  initial
  begin
    op_valid = 1'b0;
    op_code = FPNAN_OP_ARITH;
    op_fmt = FPNAN_FMT_S;
    {src_a, src_b, dst, cc_index, cmp_cond} = '0;
    gpr_is_zero = 1'b0;
    cvt_src_dbl = 1'b0;
    hint = FPNAN_HINT_NONE;
    norm_result = '0;
  end
  task automatic issue(input fpnan_op_type c, input fpnan_fmt_type f, input logic [4:0] a,
    input logic [4:0] b, input logic [4:0] d, input logic [2:0] cc, input logic [3:0] cond,
    input fpnan_hint_type h, input logic [63:0] n);
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_fmt <= f;
    src_a <= a;
    src_b <= b;
    dst <= d;
    cc_index <= (c == FPNAN_OP_COMPARE && f == FPNAN_FMT_PS) ? {cc[2:1], 1'b0} : cc;
    cmp_cond <= cond;
    hint <= h;
    norm_result <= n;
    gpr_is_zero <= ~gpr_is_zero;
    cvt_src_dbl <= (f == FPNAN_FMT_L);
    @(posedge clk);
    op_valid <= 1'b0;
    // Released lines change, so a stale operand can never pass for a live one.
    norm_result <= ~n;
    src_a <= ~a;
    src_b <= ~b;
    dst <= ~d;
  endtask
endmodule

/* testbench/fpnan_unit_bench.sv */
// Self-checking bench for the special-operand unit.
`timescale 1ns/1ps
`include "fpnan_params.svh"
module fpnan_unit_bench
  import fpnan_pkg::*;
;
  logic clk, rst_b, wr_stb, rd_stb, width_mode, op_valid, gz, dbl, done, inv, trap, unsup;
  logic [4:0]     addr, sa, sb, ds;
  logic [31:0]    wdata, rdata, w, r1, r2;
  logic [2:0]     cc;
  logic [3:0]     cond;
  logic [7:0]     ccx;
  logic [63:0]    norm, result;
  fpnan_op_type   code;
  fpnan_fmt_type  fmt;
  fpnan_hint_type hint;
  int n_errors, n_checks, idx;
  logic [31:0] seed = 32'h4e30;
  fpnan_unit #(.NEW_NAN_CAPABLE(1'b1)) dut (.CLK(clk), .RST_B(rst_b), .ADDR(addr),
    .WDATA(wdata), .WR(wr_stb), .RD(rd_stb), .RDATA(rdata), .WIDTH_MODE(width_mode),
    .OP_VALID(op_valid), .OP_CODE(code), .OP_FMT(fmt), .SRC_A(sa), .SRC_B(sb), .DST(ds),
    .CC_INDEX(cc), .CMP_COND(cond), .GPR_IS_ZERO(gz), .CVT_SRC_DBL(dbl), .HINT(hint),
    .NORM_RESULT(norm), .RESULT(result), .DONE(done), .INVALID(inv), .TRAP(trap),
    .UNSUPPORTED(unsup));
  fpnan_cpu_model cpu (.clk(clk), .op_valid(op_valid), .op_code(code), .op_fmt(fmt),
    .src_a(sa), .src_b(sb), .dst(ds), .cc_index(cc), .cmp_cond(cond), .gpr_is_zero(gz),
    .cvt_src_dbl(dbl), .hint(hint), .norm_result(norm));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [63:0] cvt_exp(logic lng, logic m, int k);
    logic [63:0] v;
    v = 64'h7fffffffffffffff;
    if (m && k == 1)
      v = 64'h8000000000000000;
    if (m && k == 2)
      v = 64'h0;
    return lng ? v : {32'h0, v[63:32]};
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk_data(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask
  task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic chk_rd(input logic [4:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk_data({32'h0, rdata}, {32'h0, e});
  endtask
  task automatic op(input fpnan_op_type c, input fpnan_fmt_type f, input logic [4:0] a,
    input logic [4:0] b, input logic [4:0] d, input fpnan_hint_type h, input logic [63:0] n);
    cpu.issue(c, f, a, b, d, 3'h0, 4'h0, h, n);
    #1;
    chk_flag(done, 1'b1);
  endtask
  task automatic cmp(input fpnan_fmt_type f, input logic [4:0] a, input logic [2:0] c,
    input logic [3:0] k, input logic [63:0] n);
    cpu.issue(FPNAN_OP_COMPARE, f, a, 5'h0a, 5'h0, c, k, FPNAN_HINT_NONE, n);
    #1;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end
  initial
  begin
    {rst_b, wr_stb, rd_stb, addr, wdata, ccx} = '0;
    width_mode = 1'b1;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    chk_rd(5'h1f, 32'h0);
    chk_rd(5'h00, `FPNAN_ID_CAPS | (32'h1 << 23) | 32'h00005a01);
    bus_wr(5'h00, 32'hffffffff);
    chk_rd(5'h00, `FPNAN_ID_CAPS | (32'h1 << 23) | 32'h00005a01);
    chk_rd(5'h05, 32'h0);
    repeat (4)
    begin
      w = xs();
      bus_wr(5'h1f, w);
      chk_rd(5'h1f, w & 32'hfe87ffff);
      chk_rd(5'h19, {24'h0, w[31:25], w[23]});
      chk_rd(5'h1a, w & 32'h0003f07c);
      chk_rd(5'h1c, w & 32'h00000f83);
    end
    bus_wr(5'h1f, 32'h0);
    op(FPNAN_OP_MOVE_IN, FPNAN_FMT_S, 0, 0, 1, FPNAN_HINT_NONE, 64'h7fffffff);
    op(FPNAN_OP_MOVE_IN, FPNAN_FMT_S, 0, 0, 2, FPNAN_HINT_NONE, 64'h7fbf0001);
    op(FPNAN_OP_ARITH, FPNAN_FMT_S, 2, 1, 3, FPNAN_HINT_NONE, 64'h0);
    chk_flag(inv, 1'b1);
    chk_data({32'h0, result[31:0]}, 64'h7fbfffff);
    op(FPNAN_OP_ARITH, FPNAN_FMT_S, 2, 2, 3, FPNAN_HINT_NONE, 64'h0);
    chk_flag(inv, 1'b0);
    chk_data({32'h0, result[31:0]}, 64'h7fbf0001);
    for (int c = 3; c <= 7; c++)
    begin
      op(fpnan_op_type'(c), FPNAN_FMT_S, 1, 1, 3, FPNAN_HINT_NONE, 64'h0);
      chk_flag(inv, 1'b0);
    end
    op(FPNAN_OP_COPY, FPNAN_FMT_S, 1, 1, 3, FPNAN_HINT_NONE, 64'h0);
    chk_data({32'h0, result[31:0]}, 64'h7fffffff);
    op(FPNAN_OP_ARITH, FPNAN_FMT_D, 10, 10, 3, FPNAN_HINT_INVALID, 64'h0);
    chk_flag(inv, 1'b1);
    chk_data(result, 64'h7ff7ffffffffffff);
    cmp(FPNAN_FMT_S, 2, 0, 4'h9, 64'h0);
    chk_flag(inv, 1'b1);
    cmp(FPNAN_FMT_S, 2, 1, 4'h0, 64'h3);
    chk_flag(inv, 1'b0);
    chk_rd(5'h19, 32'h1);
    for (int m = 0; m < 2; m++)
    begin
      bus_wr(5'h1f, 32'(m) << 18);
      for (int k = 0; k < 3; k++)
        for (int l = 0; l < 2; l++)
        begin
          op(FPNAN_OP_CVT, l ? FPNAN_FMT_L : FPNAN_FMT_W, k == 2 ? 3 : 10, 0, 11,
            k == 0 ? FPNAN_HINT_POS_OVF : k == 1 ? FPNAN_HINT_NEG_OVF : FPNAN_HINT_NONE, 64'h0);
          chk_flag(inv, 1'b1);
          chk_data(l ? result : {32'h0, result[31:0]}, cvt_exp(l[0], m[0], k));
        end
    end
    op(FPNAN_OP_MOVE_IN, FPNAN_FMT_S, 0, 0, 4, FPNAN_HINT_NONE, 64'h7fa00001);
    op(FPNAN_OP_MOVE_IN, FPNAN_FMT_S, 0, 0, 5, FPNAN_HINT_NONE, 64'h7fc12345);
    op(FPNAN_OP_ARITH, FPNAN_FMT_S, 5, 4, 3, FPNAN_HINT_NONE, 64'h0);
    chk_flag(inv, 1'b1);
    chk_data({32'h0, result[31:0]}, 64'h7fe00001);
    op(FPNAN_OP_ARITH, FPNAN_FMT_S, 5, 5, 3, FPNAN_HINT_NONE, 64'h0);
    chk_data({32'h0, result[31:0]}, 64'h7fc12345);
    op(FPNAN_OP_ARITH, FPNAN_FMT_S, 10, 10, 3, FPNAN_HINT_INVALID, 64'h0);
    chk_data({32'h0, result[31:0]}, 64'h7fc00000);
    op(FPNAN_OP_ARITH, FPNAN_FMT_D, 10, 10, 3, FPNAN_HINT_INVALID, 64'h0);
    chk_data(result, 64'h7ff8000000000000);
    op(FPNAN_OP_MOVE_IN, FPNAN_FMT_D, 0, 0, 6, FPNAN_HINT_NONE, 64'h7fa000013f800000);
    op(FPNAN_OP_ARITH, FPNAN_FMT_PS, 6, 6, 7, FPNAN_HINT_NONE, 64'h0);
    chk_flag(inv, 1'b1);
    chk_data({32'h0, result[63:32]}, 64'h7fe00001);
    repeat (4)
    begin
      idx = int'(xs() & 32'h6);
      w = xs();
      cmp(FPNAN_FMT_PS, 10, idx[2:0], 4'h0, {62'h0, w[1:0]});
      ccx[idx] = w[0];
      ccx[idx + 1] = w[1];
      chk_rd(5'h19, {24'h0, ccx});
    end
    bus_wr(5'h1f, 32'h00000800);
    op(FPNAN_OP_ARITH, FPNAN_FMT_S, 1, 1, 5, FPNAN_HINT_NONE, 64'h0);
    chk_flag(trap, 1'b1);
    chk_rd(5'h1a, 32'h00010000);
    @(posedge clk);
    width_mode <= 1'b0;
    op(FPNAN_OP_COPY, FPNAN_FMT_L, 10, 10, 3, FPNAN_HINT_NONE, 64'h0);
    chk_flag(unsup, 1'b1);
    op(FPNAN_OP_COPY, FPNAN_FMT_PS, 10, 10, 3, FPNAN_HINT_NONE, 64'h0);
    chk_flag(unsup, 1'b1);
    r1 = xs();
    r2 = xs();
    op(FPNAN_OP_MOVE_IN, FPNAN_FMT_S, 0, 0, 8, FPNAN_HINT_NONE, {32'h0, r1});
    op(FPNAN_OP_MOVE_IN, FPNAN_FMT_S, 0, 0, 9, FPNAN_HINT_NONE, {32'h0, r2});
    op(FPNAN_OP_MOVE_OUT, FPNAN_FMT_D, 9, 0, 0, FPNAN_HINT_NONE, 64'h0);
    chk_data(result, {r2, r1});
    @(posedge clk);
    width_mode <= 1'b1;
    op(FPNAN_OP_MOVE_IN, FPNAN_FMT_D, 0, 0, 12, FPNAN_HINT_NONE, {r1, r2});
    op(FPNAN_OP_MOVE_OUT, FPNAN_FMT_D, 12, 0, 0, FPNAN_HINT_NONE, 64'h0);
    chk_data(result, {r1, r2});
    tally_and_finish();
  end
endmodule
